// *** oovfc_core.sv ***
// output overvoltage fault control: threshold and action registers,
// fault flags, alert pin and the shutdown, latch and retry sequence.
// assumes a pmbus engine on mclk_i delivering decoded commands and
// clear_faults pulses; voltages come from an adc on the same clock.
`timescale 1ns/1ps
module oovfc_core import oovfc_pkg::*; #(
	parameter int unsigned RETRY_CYCLES = RETRY_DELAY_CYCLES,
	parameter logic [THR_W-1:0] THR_RESET = THR_RESET_CODE
) (
	// clock, reset, clock enable
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// command port from the protocol engine
	input wire oovfc_req_t req_i,
	output oovfc_rsp_t rsp_o,
	input wire logic clear_faults_i,
	// non-volatile image
	input wire logic nvm_restore_i,
	input wire oovfc_nvm_t nvm_image_i,
	output oovfc_nvm_t nvm_image_o,
	// voltages and sequencing
	input wire logic [VOLT_W-1:0] vout_target_i,
	input wire logic [VOLT_W-1:0] vout_sense_i,
	input wire logic soft_start_done_i,
	input wire logic fixed_overvoltage_select_i,
	// pins
	input wire logic fixed_trip_pin_i,
	input wire logic enable_pin_i,
	// converter control
	output logic conv_enable_o,
	output logic restart_o,
	// status and alert
	output oovfc_status_t status_o,
	output logic smbalert_o,
	output logic smbalert_oe_n_o
);
	localparam int unsigned CNT_W = $clog2(RETRY_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RETRY_CYCLES - 1);

	typedef enum logic [1:0] {
		ST_RUN,
		ST_LATCH,
		ST_WAIT
	} oovfc_state_t;

	// register fields
	logic [THR_W-1:0] threshold;
	logic act_on_overvoltage_n_ignore;
	logic overvoltage_retry_select;
	// fault state
	logic ov_flag;
	logic invalid_flag;
	logic act_pending;
	logic next_ov_flag;
	logic next_invalid_flag;
	logic next_act_pending;
	oovfc_state_t state;
	oovfc_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic next_restart;
	logic next_conv_enable;
	logic alert_oe_n;
	oovfc_rsp_t rsp;
	// synchronised pins
	logic fixed_trip_sync;
	logic enable_sync;
	logic rel_trip;

	// pins pass two flip-flops before use
	oovfc_sync #(
		.WIDTH(2)
	) u_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.async_i({fixed_trip_pin_i, enable_pin_i}),
		.sync_o({fixed_trip_sync, enable_sync})
	);

	// relative comparator on the commanded target
	oovfc_trip u_trip (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.code_i(threshold),
		.vout_target_i(vout_target_i),
		.vout_sense_i(vout_sense_i),
		.trip_o(rel_trip)
	);

	// command decode
	wire is_write = req_i.valid && req_i.write;
	wire is_read = req_i.valid && !req_i.write;
	wire hit_thr = req_i.code == CMD_THRESHOLD;
	wire hit_act = req_i.code == CMD_ACTION;
	wire wr_thr = is_write && hit_thr;
	wire wr_act = is_write && hit_act;
	wire [2:0] wr_retry = req_i.data[RETRY_MSB:RETRY_LSB];
	// only uniform retry codes are legal
	wire retry_ok = (wr_retry == RETRY_LATCH) || (wr_retry == RETRY_AUTO);
	wire wr_act_ok = wr_act && retry_ok;
	wire wr_act_bad = wr_act && !retry_ok;

	// read words: reserved bits zero, delay mirrors retry
	wire [2:0] retry_field = {3{overvoltage_retry_select}};
	wire [7:0] act_byte = {act_on_overvoltage_n_ignore, 1'b0,
		retry_field, retry_field};
	wire [DATA_W-1:0] thr_word = {{(DATA_W-THR_W){1'b0}}, threshold};
	wire [DATA_W-1:0] act_word = {{(DATA_W-8){1'b0}}, act_byte};
	wire [DATA_W-1:0] rd_word = hit_thr ? thr_word :
		(hit_act ? act_word : {DATA_W{1'b0}});

	// fault sources: tracking gated by soft-start
	wire track_en = soft_start_done_i;
	wire ov_event = (track_en && rel_trip)
		|| (fixed_overvoltage_select_i && fixed_trip_sync);
	// an earlier pending fault is acted on once enabled
	wire take_action = (state == ST_RUN) && act_on_overvoltage_n_ignore
		&& act_pending;

	// register file; restore wins over a write in the same cycle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			threshold <= THR_RESET;
			act_on_overvoltage_n_ignore <= ACT_RESET;
			overvoltage_retry_select <= RETRY_RESET;
		end else if (ce_i) begin
			if (nvm_restore_i) begin
				threshold <= nvm_image_i.threshold;
				act_on_overvoltage_n_ignore <= nvm_image_i.act;
				overvoltage_retry_select <= nvm_image_i.retry;
			end else begin
				if (wr_thr) begin
					threshold <= req_i.data[THR_W-1:0];
				end
				if (wr_act_ok) begin
					act_on_overvoltage_n_ignore <= req_i.data[ACT_BIT];
					overvoltage_retry_select <= req_i.data[RETRY_MSB];
				end
			end
		end
	end

	// read answer registered, one cycle after the request
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp <= '0;
		end else if (ce_i) begin
			rsp.valid <= is_read;
			rsp.hit <= is_read && (hit_thr || hit_act);
			rsp.data <= is_read ? rd_word : {DATA_W{1'b0}};
		end
	end

	// sticky flags: a set in the clear cycle wins
	assign next_ov_flag = ov_event || (ov_flag && !clear_faults_i);
	assign next_invalid_flag = wr_act_bad
		|| (invalid_flag && !clear_faults_i);
	// pending survives ignore mode until acted on or cleared
	// only faults seen while running are noted, so a fault that ends
	// during the retry wait does not re-arm another shutdown
	assign next_act_pending = (ov_event && (state == ST_RUN) && !take_action)
		|| (act_pending && !clear_faults_i && !take_action);

	// sequence: ignore keeps running, else latch or timed retry
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_restart = 1'b0;
		case (state)
			ST_RUN: begin
				// act bit low never leaves this state
				next_cnt = '0;
				if (take_action) begin
					next_state = overvoltage_retry_select ? ST_WAIT
						: ST_LATCH;
				end
			end
			ST_LATCH: begin
				// no restart scheduled; enable low releases
				if (!enable_sync) begin
					next_state = ST_RUN;
				end
			end
			ST_WAIT: begin
				// fixed delay, then normal startup, no limit
				if (cnt == CNT_LAST) begin
					next_state = ST_RUN;
					next_restart = 1'b1;
					next_cnt = '0;
				end else begin
					next_cnt = cnt + CNT_W'(1);
				end
			end
			default: begin
				next_state = ST_RUN;
				next_cnt = '0;
			end
		endcase
	end

	// output follows the state the sequencer is entering
	assign next_conv_enable = (next_state == ST_RUN) && enable_sync;

	// state, counter, flags and registered outputs
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ST_RUN;
			cnt <= '0;
			ov_flag <= 1'b0;
			invalid_flag <= 1'b0;
			act_pending <= 1'b0;
			restart_o <= 1'b0;
			conv_enable_o <= 1'b0;
			alert_oe_n <= 1'b1;
		end else if (ce_i) begin
			state <= next_state;
			cnt <= next_cnt;
			ov_flag <= next_ov_flag;
			invalid_flag <= next_invalid_flag;
			act_pending <= next_act_pending;
			restart_o <= next_restart;
			conv_enable_o <= next_conv_enable;
			// open drain: oe low pulls the line
			alert_oe_n <= !(next_ov_flag || next_invalid_flag);
		end
	end

	// status flags and alert pin; all three report one fault
	assign status_o.byte_overvoltage = ov_flag;
	assign status_o.word_vout_summary = ov_flag;
	assign status_o.vout_overvoltage = ov_flag;
	assign status_o.cml_invalid_data = invalid_flag;
	assign smbalert_o = 1'b0;
	assign smbalert_oe_n_o = alert_oe_n;
	assign rsp_o = rsp;
	// image for storage keeps one retry bit only
	assign nvm_image_o = '{threshold: threshold,
		act: act_on_overvoltage_n_ignore,
		retry: overvoltage_retry_select};

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	thr_write_a: assert property (
		ce_i && wr_thr && !nvm_restore_i
		|=> threshold == $past(req_i.data[THR_W-1:0]))
		else $error("threshold write not stored");
	rsvd_zero_a: assert property (
		ce_i && is_read
		|=> rsp_o.data[DATA_W-1:THR_W] == '0 && (!$past(hit_act)
		|| rsp_o.data[DATA_W-1:ACT_BIT+1] == '0 && !rsp_o.data[6]))
		else $error("reserved bits read nonzero");
	delay_mirror_a: assert property (
		ce_i && is_read && hit_act
		|=> rsp_o.data[DELAY_MSB:0] == rsp_o.data[RETRY_MSB:RETRY_LSB])
		else $error("delay field differs from retry field");
	bad_retry_a: assert property (
		ce_i && wr_act_bad && !nvm_restore_i
		|=> $stable(overvoltage_retry_select)
		&& $stable(act_on_overvoltage_n_ignore) && invalid_flag
		&& !smbalert_oe_n_o)
		else $error("illegal retry code accepted");
	track_gate_a: assert property (
		!soft_start_done_i && !fixed_overvoltage_select_i |-> !ov_event)
		else $error("tracking fault during soft start");
	status_set_a: assert property (
		ce_i && ov_event
		|=> status_o.byte_overvoltage && status_o.word_vout_summary
		&& status_o.vout_overvoltage && !smbalert_oe_n_o)
		else $error("fault flags or alert missing");
	ignore_run_a: assert property (
		ce_i && state == ST_RUN && !act_on_overvoltage_n_ignore
		|=> state == ST_RUN)
		else $error("ignored fault stopped conversion");
	shut_down_a: assert property (
		ce_i && take_action |=> !conv_enable_o ##1 !conv_enable_o)
		else $error("output not disabled on fault");
	latch_hold_a: assert property (
		ce_i && state == ST_LATCH && enable_sync
		|=> state == ST_LATCH && !restart_o)
		else $error("latched fault left without enable toggle");
	retry_end_a: assert property (
		ce_i && state == ST_WAIT && cnt == CNT_LAST
		|=> restart_o && state == ST_RUN)
		else $error("retry delay end missed");
	wait_bound_a: assert property (
		state == ST_WAIT |-> cnt <= CNT_LAST && !conv_enable_o)
		else $error("retry wait overran");

	ignore_cv: cover property (
		ov_event && !act_on_overvoltage_n_ignore && state == ST_RUN);
	latch_cv: cover property (state == ST_RUN ##1 state == ST_LATCH);
	restart_cv: cover property (restart_o);
	invalid_cv: cover property (ce_i && wr_act_bad);
endmodule : oovfc_core

// *** oovfc_pkg.sv ***
// shared constants, field layout and carrier types of the output
// overvoltage fault control block.
// assumes a pmbus protocol engine that decodes commands on mclk_i.
//
// Overview of operation
// - eleven-bit threshold code, relative to commanded output
// - code bands select 12, 16, 20, 50 percent
// - tracking comparison only after soft-start completes
// - unused threshold and action bits read zero
// - action covers relative and fixed threshold faults
// - fault sets three status flags, raises alert
// - act bit low keeps converting through faults
// - act bit high disables output, then latches off or retries
// - uncleared ignored fault acted on when enabled
// - retry 000b latches off until enable toggle
// - retry 111b restarts after 52ms, unlimited
// - retry field accepts only 000b or 111b
// - only bit five stored, replicated on restore
// - delay field read-only mirror of retry field
// - delay 000b never schedules a restart
// - delay 111b waits 52ms, then normal startup
// - invalid data sets status and alerts host
package oovfc_pkg;
	// widths
	localparam int unsigned DATA_W = 16;
	localparam int unsigned THR_W = 11;
	localparam int unsigned VOLT_W = 16;
	localparam int unsigned PCT_W = 8;
	localparam int unsigned PROD_W = 24;
	// command codes
	localparam logic [7:0] CMD_THRESHOLD = 8'h40;
	localparam logic [7:0] CMD_ACTION = 8'h41;
	// action register layout
	localparam int unsigned ACT_BIT = 7;
	localparam int unsigned RETRY_MSB = 5;
	localparam int unsigned RETRY_LSB = 3;
	localparam int unsigned DELAY_MSB = 2;
	localparam logic [2:0] RETRY_LATCH = 3'h0;
	localparam logic [2:0] RETRY_AUTO = 3'h7;
	// reset values until the non-volatile image is restored
	localparam logic [THR_W-1:0] THR_RESET_CODE = 11'h248;
	localparam logic ACT_RESET = 1'b1;
	localparam logic RETRY_RESET = 1'b0;
	// threshold code band edges and percentages
	localparam logic [THR_W-1:0] BAND_16 = 11'h248;
	localparam logic [THR_W-1:0] BAND_20 = 11'h25C;
	localparam logic [THR_W-1:0] BAND_50 = 11'h29A;
	localparam logic [PCT_W-1:0] PCT_12 = 8'h0C;
	localparam logic [PCT_W-1:0] PCT_16 = 8'h10;
	localparam logic [PCT_W-1:0] PCT_20 = 8'h14;
	localparam logic [PCT_W-1:0] PCT_50 = 8'h32;
	localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
	// retry delay: figure in microseconds, clock in MHz
	localparam int unsigned RETRY_DELAY_US = 52000;
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned RETRY_DELAY_CYCLES = RETRY_DELAY_US * CLK_MHZ;

	// command from the protocol engine
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [DATA_W-1:0] data;
	} oovfc_req_t;

	// read answer, one cycle after the request
	typedef struct packed {
		logic valid;
		logic hit;
		logic [DATA_W-1:0] data;
	} oovfc_rsp_t;

	// non-volatile image: only one retry bit is kept
	typedef struct packed {
		logic [THR_W-1:0] threshold;
		logic act;
		logic retry;
	} oovfc_nvm_t;

	// status flags towards the status registers
	typedef struct packed {
		logic byte_overvoltage;
		logic word_vout_summary;
		logic vout_overvoltage;
		logic cml_invalid_data;
	} oovfc_status_t;
endpackage : oovfc_pkg

// *** oovfc_sync.sv ***
// two flip-flop synchroniser for asynchronous pins.
// assumes levels only; pulses shorter than one clock may be lost.
`timescale 1ns/1ps
module oovfc_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// pins in, synchronised levels out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	genvar g;
	// first stage feeds only the second stage
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic stage1;
			logic stage2;
			always_ff @(posedge mclk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
				end else if (ce_i) begin
					stage1 <= async_i[g];
					stage2 <= stage1;
				end
			end
			assign sync_o[g] = stage2;
		end
	endgenerate
endmodule : oovfc_sync

// *** oovfc_trip.sv ***
// relative trip comparator: target scaled by the band percentage.
// assumes target and sensed voltages share one scale and one clock.
`timescale 1ns/1ps
module oovfc_trip import oovfc_pkg::*; (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// threshold code and voltages
	input wire logic [THR_W-1:0] code_i,
	input wire logic [VOLT_W-1:0] vout_target_i,
	input wire logic [VOLT_W-1:0] vout_sense_i,
	// registered comparison
	output logic trip_o
);
	logic [PCT_W-1:0] pct_sel;
	logic [PROD_W-1:0] sense_scaled;
	logic [PROD_W-1:0] limit_scaled;

	// band select from the code
	assign pct_sel = (code_i < BAND_16) ? PCT_12 :
		(code_i < BAND_20) ? PCT_16 :
		(code_i < BAND_50) ? PCT_20 : PCT_50;
	// cross-multiplied so no divider is needed
	assign sense_scaled = PROD_W'(vout_sense_i) * PROD_W'(PCT_FULL);
	assign limit_scaled = PROD_W'(vout_target_i)
		* PROD_W'(PCT_FULL + pct_sel);

	// compared every enabled cycle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			trip_o <= 1'b0;
		end else if (ce_i) begin
			trip_o <= sense_scaled > limit_scaled;
		end
	end

	band_top_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		code_i >= BAND_50 |-> pct_sel == PCT_50)
		else $error("top band not fifty percent");
	band_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		code_i < BAND_16 |-> pct_sel == PCT_12)
		else $error("low band not twelve percent");
endmodule : oovfc_trip

// *** oovfc_host.sv ***
// pmbus host stand-in: issues decoded commands and clear pulses.
// assumes the block takes a request at a rising edge of mclk_i.
`timescale 1ns/1ps
module oovfc_host import oovfc_pkg::*; (
	// clock
	input wire logic mclk_i,
	// command side
	output oovfc_req_t req_o,
	output logic clear_faults_o
);
	// idle until the bench asks for something
	initial begin
		req_o = '0;
		clear_faults_o = 1'b0;
	end

	// one command held over exactly one taking edge; callers keep the
	// retry field at 000b or 111b unless a refusal is wanted
	task automatic send(input logic wr, input logic [7:0] code,
		input logic [15:0] data);
		@(posedge mclk_i);
		#1;
		req_o = '{valid: 1'b1, write: wr, code: code, data: data};
		@(posedge mclk_i);
		#1;
		req_o = '0;
	endtask : send

	// one-cycle clear of flags and pending faults
	task automatic clear();
		@(posedge mclk_i);
		#1;
		clear_faults_o = 1'b1;
		@(posedge mclk_i);
		#1;
		clear_faults_o = 1'b0;
	endtask : clear
endmodule : oovfc_host

// *** output_overvoltage_fault_control_tb.sv ***
// self-checking bench for the overvoltage fault control core.
// assumes oovfc_host drives commands; retry wait shortened to RC.
`timescale 1ns/1ps
module output_overvoltage_fault_control_tb import oovfc_pkg::*;;
	localparam int unsigned RC = 20;
	// stimulus, all defined at time zero
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic nvm_restore_i = 1'b0;
	oovfc_nvm_t nvm_image_i = '0;
	logic [15:0] vout_sense_i = 16'h0000;
	logic soft_start_done_i = 1'b0;
	logic fixed_sel = 1'b0;
	logic fixed_pin = 1'b0;
	logic enable_pin = 1'b1;
	// observed
	oovfc_req_t req;
	logic clr;
	oovfc_rsp_t rsp;
	oovfc_nvm_t nvm_o;
	oovfc_status_t status;
	logic conv, restart, alert, alert_oe_n;
	// bookkeeping
	int n_errors = 0;
	int checked = 0;
	int cnt;
	logic [16:0] exp_q[$];
	logic [15:0] rng = 16'h002E;
	logic [10:0] codes[7] = '{11'd583, 11'd584, 11'd603, 11'd604,
		11'd665, 11'd666, 11'd2047};
	int pct[7] = '{12, 16, 16, 20, 20, 50, 50};

	always #20 mclk_i = ~mclk_i;

	oovfc_host i_host (.mclk_i(mclk_i), .req_o(req), .clear_faults_o(clr));

	// clock enable tied high: freezing is not exercised here
	oovfc_core #(.RETRY_CYCLES(RC)) i_dut (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .ce_i(1'b1), .req_i(req), .rsp_o(rsp),
		.clear_faults_i(clr), .nvm_restore_i(nvm_restore_i),
		.nvm_image_i(nvm_image_i), .nvm_image_o(nvm_o),
		.vout_target_i(16'h03E8), .vout_sense_i(vout_sense_i),
		.soft_start_done_i(soft_start_done_i),
		.fixed_overvoltage_select_i(fixed_sel),
		.fixed_trip_pin_i(fixed_pin), .enable_pin_i(enable_pin),
		.conv_enable_o(conv), .restart_o(restart), .status_o(status),
		.smbalert_o(alert), .smbalert_oe_n_o(alert_oe_n));

	task automatic check(input string what, input logic [16:0] seen,
		input logic [16:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		if (n_errors == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	function automatic logic [15:0] xs(input logic [15:0] x);
		logic [15:0] y;
		y = x ^ (x << 7);
		y = y ^ (y >> 9);
		return y ^ (y << 8);
	endfunction : xs

	// reads note their answer first; the monitor pairs them in order
	task automatic rd(input logic [7:0] code, input logic [16:0] exp);
		exp_q.push_back(exp);
		i_host.send(1'b0, code, 16'h0000);
	endtask : rd

	task automatic wr(input logic [7:0] code, input logic [15:0] d);
		i_host.send(1'b1, code, d);
	endtask : wr

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : cyc

	// answers stand one cycle, so the falling edge sees each once
	always @(negedge mclk_i) begin
		if (rsp.valid === 1'b1) begin
			check("read", {rsp.hit, rsp.data},
				exp_q.size() > 0 ? exp_q.pop_front() : 17'h1FFFF);
		end
	end

	// a hang costs one mismatch and ends the run the usual way
	initial begin
		#(40 * 20000);
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge mclk_i);
		#1;
		rst_n_i = 1'b1;
		cyc(4);
		rd(CMD_THRESHOLD, {1'b1, 16'h0248});
		rd(CMD_ACTION, {1'b1, 16'h0080});
		rd(8'h42, 17'h00000);
		wr(CMD_THRESHOLD, 16'hFFFF);
		rd(CMD_THRESHOLD, {1'b1, 16'h07FF});
		wr(CMD_ACTION, 16'h0078);
		rd(CMD_ACTION, {1'b1, 16'h003F});
		check("image", 17'(nvm_o.retry), 17'h1);
		repeat (4) begin
			rng = xs(rng);
			wr(CMD_THRESHOLD, rng);
			rd(CMD_THRESHOLD, {1'b1, 5'h00, rng[10:0]});
		end
		// every refused retry code keeps the old byte and flags it
		for (int r = 1; r < 7; r++) begin
			wr(CMD_ACTION, 16'(128 + r * 8));
			cyc(1);
			check("ivd", {15'h0, status.cml_invalid_data, alert_oe_n},
				17'h2);
			rd(CMD_ACTION, {1'b1, 16'h003F});
			i_host.clear();
			cyc(1);
			check("cleared", 17'(status), 17'h0);
		end
		// ignore mode: no trips during the ramp, band edges afterwards
		wr(CMD_ACTION, 16'h0000);
		vout_sense_i = 16'hFFFF;
		cyc(5);
		check("ramp", 17'(status), 17'h0);
		// let the registered trip settle low before tracking starts
		vout_sense_i = 16'h0000;
		cyc(2);
		soft_start_done_i = 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(CMD_THRESHOLD, 16'(codes[i]));
			vout_sense_i = 16'(10 * (100 + pct[i]));
			cyc(4);
			check("at_level", 17'(status), 17'h0);
			vout_sense_i = vout_sense_i + 16'h0001;
			cyc(4);
			check("over", 17'(status), 17'h0E);
			check("run", {14'h0, alert, conv, alert_oe_n}, 17'h2);
			vout_sense_i = 16'h0000;
			cyc(3);
			i_host.clear();
			cyc(2);
		end
		// an ignored fault is acted on once the act bit is set
		vout_sense_i = 16'hFFFF;
		cyc(4);
		vout_sense_i = 16'h0000;
		cyc(4);
		wr(CMD_ACTION, 16'h00B8);
		cnt = 0;
		while (conv !== 1'b0 && cnt < 10) begin
			cyc(1);
			cnt++;
		end
		check("late_act", 17'(conv), 17'h0);
		cnt = 0;
		while (restart !== 1'b1 && cnt < 200) begin
			cyc(1);
			cnt++;
		end
		check("wait", 17'(cnt), 17'(RC));
		check("startup", 17'(conv), 17'h1);
		// a persisting fixed fault keeps the hiccup going
		fixed_sel = 1'b1;
		fixed_pin = 1'b1;
		for (int k = 0; k < 3; k++) begin
			cyc(2);
			cnt = 0;
			while (restart !== 1'b1 && cnt < 200) begin
				cyc(1);
				cnt++;
			end
			check("again", 17'(restart), 17'h1);
		end
		fixed_pin = 1'b0;
		cyc(RC + 10);
		i_host.clear();
		cyc(2);
		check("back", {15'h0, conv, status.vout_overvoltage}, 17'h2);
		// latch-off on the fixed path: only an enable toggle restarts
		wr(CMD_ACTION, 16'h0080);
		fixed_pin = 1'b1;
		cyc(4);
		fixed_pin = 1'b0;
		check("fixed", 17'(status), 17'h0E);
		cyc(RC + 10);
		check("latched", {15'h0, conv, restart}, 17'h0);
		i_host.clear();
		cyc(3);
		check("stay_off", 17'(conv), 17'h0);
		enable_pin = 1'b0;
		cyc(4);
		enable_pin = 1'b1;
		cyc(5);
		check("toggled", 17'(conv), 17'h1);
		// restore fills all three retry bits from one stored bit
		nvm_image_i = '{threshold: 11'h29A, act: 1'b0, retry: 1'b1};
		nvm_restore_i = 1'b1;
		cyc(1);
		nvm_restore_i = 1'b0;
		rd(CMD_THRESHOLD, {1'b1, 16'h029A});
		rd(CMD_ACTION, {1'b1, 16'h003F});
		cyc(4);
		check("unanswered", 17'(exp_q.size()), 17'h0);
		wrap_up();
	end
endmodule : output_overvoltage_fault_control_tb
